// ### hw/pbap_params.svh
`ifndef PBAP_PARAMS_SVH
`define PBAP_PARAMS_SVH
// ----------------------------------------
// configuration word fields
// ----------------------------------------
`define PBAP_CFG_SYNC_BIT 15
`define PBAP_CFG_FIXED_BIT 14
`define PBAP_CFG_LC_HI 13
`define PBAP_CFG_LC_LO 11
`define PBAP_CFG_WAIT_POL_BIT 10
`define PBAP_CFG_WAIT_TIMING_BIT 8
`define PBAP_CFG_WRAP_BIT 3
`define PBAP_CFG_RESET 16'h2a1f
// ----------------------------------------
// timing
// ----------------------------------------
`define PBAP_CLK_PERIOD_NS 8
`define PBAP_CE_MAX_LOW_US 4
`define PBAP_CE_MAX_LOW_CYC ((`PBAP_CE_MAX_LOW_US * 1000) / `PBAP_CLK_PERIOD_NS)
`define PBAP_CE_HIGH_GAP_NS 15
`define PBAP_CE_HIGH_GAP_CYC ((`PBAP_CE_HIGH_GAP_NS + `PBAP_CLK_PERIOD_NS - 1) / `PBAP_CLK_PERIOD_NS + 1)
`define PBAP_BURST_LEN 4
`define PBAP_ROW_WORDS 128
`endif

// ### hw/pbap_pkg.sv
package pbap_pkg;
  typedef enum logic [2:0] {
    PBAP_IDLE = 3'h0,
    PBAP_LAT = 3'h1,
    PBAP_DATA = 3'h3,
    PBAP_EOR = 3'h2,
    PBAP_GAP = 3'h6
  } pbap_state_t;
endpackage : pbap_pkg

// ### hw/pbap_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pbap_if;
  logic clk_en;
  logic ce_n;
  logic address_valid_n;
  logic oe_n;
  logic we_n;
  logic lower_byte_select_n;
  logic upper_byte_select_n;
  logic [21:0] addr;
  logic [15:0] dq_m2d;
  logic dq_m2d_oe;
  logic [15:0] dq_d2m;
  logic dq_d2m_oe;
  logic wait_sig;
  logic wait_oe;
  modport mem (input clk_en, ce_n, address_valid_n, oe_n, we_n, lower_byte_select_n,
    upper_byte_select_n, addr, dq_m2d, dq_m2d_oe, output dq_d2m, dq_d2m_oe, wait_sig, wait_oe);
  modport ctl (output clk_en, ce_n, address_valid_n, oe_n, we_n, lower_byte_select_n,
    upper_byte_select_n, addr, dq_m2d, dq_m2d_oe, input dq_d2m, dq_d2m_oe, wait_sig, wait_oe);
endinterface : pbap_if
`default_nettype wire

// ### hw/pbap_mem.sv
`timescale 1ns/1ns
`default_nettype none
`include "pbap_params.svh"
// Contract
// - variable latency code 2 gives four cycles
// - fixed latency adds one clock to code
// - refresh collision stretches wait up to double
// - wait polarity configurable, asserted during delay
// - write wait lasts exactly latency code cycles
// - write enable low at latch means write
// - four word wrapping bursts supported
// - controller holds clock static during suspend
// - suspended read keeps driving data
// - controller drops enable soon after row-end wait
// - controller gives refresh opportunity every period
// - enable low never beyond maximum pulse
// - read burst interruptible after first word
// - write burst interruptible after first word
// - enable low limited to four microseconds
// - enable high between async and variable bursts
// - enable high gap in synchronous mode
module pbap_mem (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // link
  pbap_if.mem bus,
  // configuration and refresh
  input wire logic [15:0] i_burst_configuration_word,
  input wire logic i_refresh_request,
  // status
  output logic o_refresh_collision,
  output logic o_burst_active
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pbap_pkg::pbap_state_t st;
    logic is_write;
    logic [4:0] lat_cnt;
    logic [21:0] addr;
    logic [1:0] wrap_cnt;
    logic [15:0] rdata;
    logic rd_oe;
    logic wait_act;
    logic wait_oe;
    logic collision;
    logic [6:0] row_off;
  } pbap_mem_t;
  pbap_mem_t s_q, s_d;
  logic [15:0] mem_q [0:255];
  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  logic [2:0] lc;
  logic fixed;
  logic wait_pol_hi;
  logic wrap_on;
  assign lc = i_burst_configuration_word[`PBAP_CFG_LC_HI:`PBAP_CFG_LC_LO];
  assign fixed = i_burst_configuration_word[`PBAP_CFG_FIXED_BIT];
  assign wait_pol_hi = i_burst_configuration_word[`PBAP_CFG_WAIT_POL_BIT];
  assign wrap_on = i_burst_configuration_word[`PBAP_CFG_WRAP_BIT];
  // ----------------------------------------
  // link decode
  // ----------------------------------------
  logic clocked;
  logic latch;
  logic wr_req;
  // the controller gates the clock; a dead edge changes nothing unless enable is high
  assign clocked = bus.clk_en;
  // a latch with enable high is ignored; enable high always wins
  assign latch = clocked && !bus.ce_n && !bus.address_valid_n;
  assign wr_req = !bus.we_n;
  // ----------------------------------------
  // latency selection
  // ----------------------------------------
  logic [4:0] lat_len;
  logic collide;
  // counts start at the latch edge itself
  always_comb begin
    collide = 1'b0;
    if (wr_req) begin
      // writes never see refresh: the wait is the bare code
      lat_len = {2'h0, lc};
    end else if (fixed) begin
      lat_len = 5'({2'h0, lc} + 5'h1);
    end else if (i_refresh_request) begin
      // refresh collision doubles the wait, worst case
      lat_len = 5'({1'b0, lc, 1'b0});
      collide = 1'b1;
    end else begin
      lat_len = 5'({2'h0, lc} + 5'h2);
    end
  end
  // ----------------------------------------
  // array index
  // ----------------------------------------
  logic [1:0] next_cnt;
  logic [7:0] widx;
  logic [7:0] ridx;
  logic [7:0] rd_idx;
  assign next_cnt = 2'(s_q.wrap_cnt + 2'h1);
  always_comb begin
    if (wrap_on) begin
      // wrap stays inside the aligned four-word block
      widx = {s_q.addr[7:2], 2'(s_q.addr[1:0] + s_q.wrap_cnt)};
      ridx = {s_q.addr[7:2], 2'(s_q.addr[1:0] + next_cnt)};
    end else begin
      // linear bursts walk on toward the row end
      widx = 8'(s_q.addr[7:0] + {6'h0, s_q.wrap_cnt});
      ridx = 8'(widx + 8'h1);
    end
  end
  // reads run one word ahead so each word stands a full cycle
  always_comb begin
    rd_idx = ridx;
    if (latch) begin
      rd_idx = bus.addr[7:0];
    end else if (s_q.st != pbap_pkg::PBAP_DATA) begin
      rd_idx = widx;
    end
  end
  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    if (bus.ce_n) begin
      // enable high ends any burst at once, whatever state
      s_d.st = pbap_pkg::PBAP_IDLE;
      s_d.rd_oe = 1'b0;
      s_d.wait_act = 1'b0;
      s_d.wait_oe = 1'b0;
      s_d.collision = 1'b0;
    end else if (latch) begin
      // a new latch abandons any burst in flight
      s_d.st = pbap_pkg::PBAP_LAT;
      s_d.is_write = wr_req;
      s_d.addr = bus.addr;
      s_d.row_off = bus.addr[6:0];
      s_d.wrap_cnt = 2'h0;
      s_d.wait_oe = 1'b1;
      s_d.rd_oe = 1'b0;
      s_d.collision = collide;
      s_d.lat_cnt = 5'(lat_len - 5'h1);
      s_d.wait_act = (lat_len > 5'h1);
      if (lat_len <= 5'h1) begin
        s_d.st = pbap_pkg::PBAP_DATA;
      end
    end else if (clocked) begin
      case (s_q.st)
        pbap_pkg::PBAP_LAT: begin
          s_d.lat_cnt = 5'(s_q.lat_cnt - 5'h1);
          if (s_q.lat_cnt <= 5'h1) begin
            s_d.st = pbap_pkg::PBAP_DATA;
            s_d.wait_act = 1'b0;
          end
        end
        pbap_pkg::PBAP_DATA: begin
          if (!wrap_on && s_q.row_off == 7'h7f) begin
            s_d.st = pbap_pkg::PBAP_EOR;
            s_d.wait_act = 1'b1;
          end
          s_d.wrap_cnt = 2'(s_q.wrap_cnt + 2'h1);
          s_d.row_off = 7'(s_q.row_off + 7'h1);
        end
        pbap_pkg::PBAP_EOR: s_d.wait_act = 1'b1;
        default: s_d.st = pbap_pkg::PBAP_IDLE;
      endcase
    end
    // suspended reads hold the last word while output enable stays low
    s_d.rd_oe = !bus.ce_n && !bus.oe_n && !s_d.is_write &&
      (s_d.st == pbap_pkg::PBAP_DATA);
    // a dead edge leaves the word standing through a suspend
    if (clocked && !bus.ce_n && !s_d.is_write && s_d.st == pbap_pkg::PBAP_DATA) begin
      s_d.rdata = mem_q[rd_idx];
    end
  end
  // ----------------------------------------
  // registers and array
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (clocked && !bus.ce_n && s_q.st == pbap_pkg::PBAP_DATA && s_q.is_write) begin
      mem_q[widx] <= bus.dq_m2d;
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // polarity is a static level, so wait needs no extra flop
  assign bus.dq_d2m = s_q.rdata;
  assign bus.dq_d2m_oe = s_q.rd_oe;
  assign bus.wait_sig = s_q.wait_act ~^ wait_pol_hi;
  assign bus.wait_oe = s_q.wait_oe;
  assign o_refresh_collision = s_q.collision;
  assign o_burst_active = s_q.wait_oe;
endmodule : pbap_mem
`default_nettype wire

// ### hw/pbap_ctl.sv
`timescale 1ns/1ns
`default_nettype none
`include "pbap_params.svh"
module pbap_ctl (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // link
  pbap_if.ctl bus,
  // user request
  input wire logic i_req,
  input wire logic i_req_write,
  input wire logic [21:0] i_req_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_suspend,
  input wire logic i_wait_timing,
  // user answer
  output logic o_busy,
  output logic o_rvalid,
  output logic [15:0] o_rdata
);
  typedef struct packed {
    pbap_pkg::pbap_state_t st;
    logic write;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic [1:0] words;
    logic [9:0] ce_cnt;
    logic [1:0] gap;
    logic [1:0] eor_cnt;
    logic ce_n;
    logic adv_n;
    logic clk_en;
    logic rvalid;
    logic [15:0] rdata;
  } pbap_ctl_t;
  pbap_ctl_t s_q, s_d;
  logic wait_on;
  // wait sampled active low, as configured
  assign wait_on = bus.wait_oe && !bus.wait_sig;
  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.adv_n = 1'b1;
    s_d.clk_en = !i_suspend;
    if (!s_q.ce_n) begin
      s_d.ce_cnt = 10'(s_q.ce_cnt + 10'h1);
    end
    case (s_q.st)
      pbap_pkg::PBAP_IDLE: begin
        if (i_req) begin
          s_d.st = pbap_pkg::PBAP_LAT;
          s_d.ce_n = 1'b0;
          s_d.adv_n = 1'b0;
          s_d.write = i_req_write;
          s_d.addr = i_req_addr;
          s_d.wdata = i_wdata;
          s_d.ce_cnt = 10'h0;
          s_d.words = 2'h0;
          s_d.clk_en = 1'b1;
        end
      end
      pbap_pkg::PBAP_LAT: begin
        if (!wait_on && s_q.adv_n && s_q.clk_en) begin
          // wait off at this edge means word one stands now
          s_d.st = pbap_pkg::PBAP_DATA;
          s_d.words = 2'h1;
          if (!s_q.write) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = bus.dq_d2m;
          end
        end
      end
      pbap_pkg::PBAP_DATA: begin
        if (wait_on && i_wait_timing) begin
          s_d.st = pbap_pkg::PBAP_EOR;
          s_d.eor_cnt = 2'h0;
        end else if (wait_on) begin
          // early wait timing leaves no spare edge
          s_d.st = pbap_pkg::PBAP_GAP;
          s_d.ce_n = 1'b1;
          s_d.gap = 2'h0;
        end else if (s_q.clk_en) begin
          if (!s_q.write) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = bus.dq_d2m;
          end
          s_d.words = 2'(s_q.words + 2'h1);
          if (s_q.words == 2'h3) begin
            s_d.st = pbap_pkg::PBAP_GAP;
            s_d.ce_n = 1'b1;
            s_d.gap = 2'h0;
          end else if (i_req && s_q.ce_cnt < 10'(`PBAP_CE_MAX_LOW_CYC - 40)) begin
            // interrupt after the first word keeps enable low
            s_d.st = pbap_pkg::PBAP_LAT;
            s_d.adv_n = 1'b0;
            s_d.write = i_req_write;
            s_d.addr = i_req_addr;
            s_d.wdata = i_wdata;
            s_d.words = 2'h0;
          end
        end
      end
      pbap_pkg::PBAP_EOR: begin
        s_d.eor_cnt = 2'(s_q.eor_cnt + 2'h1);
        if (s_q.eor_cnt == 2'h0) begin
          s_d.st = pbap_pkg::PBAP_GAP;
          s_d.ce_n = 1'b1;
          s_d.gap = 2'h0;
        end
      end
      pbap_pkg::PBAP_GAP: begin
        // a fixed high gap covers refresh and mode changes alike
        s_d.gap = 2'(s_q.gap + 2'h1);
        if (s_q.gap == 2'(`PBAP_CE_HIGH_GAP_CYC - 1)) begin
          s_d.st = pbap_pkg::PBAP_IDLE;
        end
      end
      default: s_d.st = pbap_pkg::PBAP_IDLE;
    endcase
    if (!s_q.ce_n && s_q.ce_cnt >= 10'(`PBAP_CE_MAX_LOW_CYC - 4)) begin
      s_d.st = pbap_pkg::PBAP_GAP;
      s_d.ce_n = 1'b1;
      s_d.gap = 2'h0;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
      s_q.ce_n <= 1'b1;
      s_q.adv_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  assign bus.clk_en = s_q.clk_en;
  assign bus.ce_n = s_q.ce_n;
  assign bus.address_valid_n = s_q.adv_n;
  assign bus.oe_n = s_q.ce_n || s_q.write;
  assign bus.we_n = !s_q.write;
  assign bus.lower_byte_select_n = s_q.ce_n;
  assign bus.upper_byte_select_n = s_q.ce_n;
  assign bus.addr = s_q.addr;
  assign bus.dq_m2d = s_q.wdata;
  assign bus.dq_m2d_oe = !s_q.ce_n && s_q.write;
  assign o_busy = s_q.st != pbap_pkg::PBAP_IDLE;
  assign o_rvalid = s_q.rvalid;
  assign o_rdata = s_q.rdata;
endmodule : pbap_ctl
`default_nettype wire

// ### verification/pbap_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// link checker
// ----------------------------------------
module pbap_chk (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // memory side
  input wire logic [15:0] i_burst_configuration_word,
  input wire logic o_refresh_collision,
  // link
  input wire logic clk_en,
  input wire logic ce_n,
  input wire logic address_valid_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [15:0] dq_d2m,
  input wire logic dq_d2m_oe,
  input wire logic wait_sig,
  input wire logic wait_oe
);
  logic lat, wa, done, fx, wt, arm_q, rd_q, dph_q;
  logic [3:0] wc_q;
  logic [3:0] lc;
  logic [9:0] low_q;
  assign lat = clk_en && !ce_n && !address_valid_n;
  assign wa = wait_oe && (wait_sig == i_burst_configuration_word[10]);
  assign lc = {1'b0, i_burst_configuration_word[13:11]};
  assign fx = i_burst_configuration_word[14];
  assign wt = i_burst_configuration_word[8];
  assign done = arm_q && !wa;
  // counts sampled wait cycles only, so edge alignment cannot skew it
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      arm_q <= 1'b0;
      rd_q <= 1'b0;
      dph_q <= 1'b0;
      wc_q <= 4'h0;
      low_q <= 10'h0;
    end else begin
      arm_q <= lat || (arm_q && wa);
      rd_q <= lat ? we_n : rd_q;
      dph_q <= !lat && !ce_n && (dph_q || done);
      wc_q <= lat ? 4'h0 : wc_q + {3'h0, arm_q && wa};
      low_q <= ce_n ? 10'h0 : low_q + 10'h1;
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  a_var_read_lat: assert property (done && rd_q && !fx && !o_refresh_collision |-> wc_q == lc + 4'h1)
    else $error("variable read latency wrong");
  a_fixed_read_lat: assert property (done && rd_q && fx |-> wc_q == lc)
    else $error("fixed read latency wrong");
  a_collision_span: assert property (done && rd_q && !fx && o_refresh_collision |-> wc_q >= lc && wc_q <= {lc[2:0], 1'b0})
    else $error("collision wait span wrong");
  a_write_wait: assert property (done && !rd_q |-> wc_q == lc - 4'h1)
    else $error("write wait length wrong");
  a_write_no_drive: assert property (lat && !we_n |=> !dq_d2m_oe [*4])
    else $error("data driven in write");
  a_suspend_hold: assert property (dph_q && rd_q && !oe_n && !clk_en && !$past(clk_en) |-> dq_d2m_oe && $stable(dq_d2m))
    else $error("data lost in suspend");
  a_row_end_fast: assert property (dph_q && $rose(wa) && !wt |-> ##[0:1] ce_n)
    else $error("late enable release");
  a_row_end_slow: assert property (dph_q && $rose(wa) && wt |-> ##[0:2] ce_n)
    else $error("late enable release");
  a_interrupt_order: assert property (lat |-> !arm_q)
    else $error("burst cut before first word");
  a_enable_gap: assert property ($rose(ce_n) |-> ce_n [*3])
    else $error("enable high gap short");
  a_enable_max_low: assert property (low_q < 10'h1f4)
    else $error("enable low too long");
endmodule : pbap_chk
`default_nettype wire

// ### verification/pbap_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module pbap_tb_top;
  // ----------------------------------------
  // stimulus and harness
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] cfg = 16'h0;
  logic refr = 1'b0;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [21:0] addr = 22'h0;
  logic [15:0] wd = 16'h0;
  logic susp = 1'b0;
  logic wt = 1'b0;
  logic busy, rv, coll, act, sawc;
  logic [15:0] rd;
  logic [15:0] got[$];
  int err_total = 0;
  int comparisons = 0;
  localparam logic [3:0] mode_tab [4] = '{4'h2, 4'h3, 4'ha, 4'hc};
  always #4 clk = ~clk;
  pbap_if pbap_if_i ();
  pbap_mem pbap_mem_i (.i_core_clk(clk), .i_rst_b(rst_b), .bus(pbap_if_i), .i_burst_configuration_word(cfg),
    .i_refresh_request(refr), .o_refresh_collision(coll), .o_burst_active(act));
  pbap_ctl pbap_ctl_i (.i_core_clk(clk), .i_rst_b(rst_b), .bus(pbap_if_i), .i_req(req), .i_req_write(wr),
    .i_req_addr(addr), .i_wdata(wd), .i_suspend(susp), .i_wait_timing(wt), .o_busy(busy), .o_rvalid(rv),
    .o_rdata(rd));
  pbap_chk pbap_chk_i (.i_core_clk(clk), .i_rst_b(rst_b), .i_burst_configuration_word(cfg),
    .o_refresh_collision(coll), .clk_en(pbap_if_i.clk_en), .ce_n(pbap_if_i.ce_n),
    .address_valid_n(pbap_if_i.address_valid_n), .oe_n(pbap_if_i.oe_n), .we_n(pbap_if_i.we_n),
    .dq_d2m(pbap_if_i.dq_d2m), .dq_d2m_oe(pbap_if_i.dq_d2m_oe), .wait_sig(pbap_if_i.wait_sig),
    .wait_oe(pbap_if_i.wait_oe));
  // wait is kept active low, the only polarity the controller reads
  function automatic logic [15:0] mk(input logic f, input logic [2:0] l, input logic wrap, input logic t);
    return {1'b0, f, l, 2'h0, t, 4'h0, wrap, 3'h7};
  endfunction : mk
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  // one burst; optional suspend, optional write cutting in after word one
  task automatic acc(input logic w, input logic [21:0] a, input logic [15:0] d, input int sus, input logic ion);
    int n;
    got = {};
    sawc = 1'b0;
    @(negedge clk);
    wr = w;
    addr = a;
    wd = d;
    req = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    req = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      sawc = sawc | (coll === 1'b1);
      if (req && pbap_if_i.address_valid_n === 1'b0) req = 1'b0;
      if (susp) begin
        sus--;
        susp = (sus > 0);
      end
      if (rv === 1'b1) begin
        got.push_back(rd);
        if (got.size() == 1) begin
          susp = (sus > 0);
          if (ion) begin
            wr = 1'b1;
            addr = a ^ 22'h10;
            req = 1'b1;
          end
        end
      end
      @(negedge clk);
      n++;
    end
    check("idle", {15'h0, busy}, 16'h0);
    check("act", {15'h0, act}, 16'h0);
  endtask : acc
  initial begin
    logic [3:0] m;
    logic [21:0] a;
    logic [15:0] d;
    void'($urandom(32'hf484));
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    for (int k = 0; k < 12; k++) begin
      m = mode_tab[k % 4];
      cfg = mk(m[3], m[2:0], 1'b1, 1'b0);
      a = 22'($urandom);
      d = 16'($urandom);
      acc(1'b1, a, d, 0, 1'b0);
      refr = !m[3] && k[2];
      acc(1'b0, a ^ 22'($urandom % 4), 16'h0, k % 3 * 3, 1'b0);
      refr = 1'b0;
      check("coll", {15'h0, sawc}, {15'h0, !m[3] && k[2]});
      check("count", 16'(got.size()), 16'h4);
      foreach (got[i]) check("word", got[i], d);
    end
    $display("test modes done");
    cfg = mk(1'b0, 3'h2, 1'b1, 1'b0);
    acc(1'b0, a, d ^ 16'h5a5a, 0, 1'b1);
    check("first", got[0], d);
    acc(1'b0, a ^ 22'h10, 16'h0, 0, 1'b0);
    check("cut", got[0], d ^ 16'h5a5a);
    $display("test interrupt done");
    // linear bursts run into the row end with both wait timings
    for (int t = 0; t < 2; t++) begin
      cfg = mk(1'b0, 3'h2, 1'b0, t[0]);
      wt = t[0];
      d = 16'($urandom);
      acc(1'b1, 22'h7e, d, 0, 1'b0);
      acc(1'b0, 22'h7e, 16'h0, 0, 1'b0);
      check("row", got[0], d);
    end
    $display("test row end done");
    end_sim();
  end
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule : pbap_tb_top
`default_nettype wire
